// ### core/thl_core.sv
// Hardware-limit control and external reset selection for an 8-bit period timer.
// Assumes timer_input_clock_i is a level synchronous to clk_i, and
// instr_clk_en_i is a one-cycle tick marking each instruction clock.
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
module thl_core
  import thl_pkg::*;
#(
  parameter int         CNT_W    = 8,
  parameter logic [4:0] OWN_CODE = 5'h01
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [DATA_W-1:0] avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              timer_input_clock_i,
  input  wire logic              instr_clk_en_i,
  input  wire logic              sleep_i,
  input  wire logic              timer_input_pin_select_i,
  input  wire logic [3:0]        other_timer_postscaled_out_i,
  input  wire logic [3:0]        capture_compare_out_i,
  input  wire logic [7:0]        pulse_width_out_i,
  input  wire logic [7:0]        synced_comparator_out_i,
  input  wire logic              zero_cross_out_i,
  input  wire logic [3:0]        logic_cell_out_i,
  output logic      [CNT_W-1:0]  timer_count_o,
  output logic                   timer_match_o,
  output logic                   timer_running_o
);

  // Software-visible registers.
  logic [7:0]       hardware_limit_control;
  logic [4:0]       external_reset_select;
  logic             on_bit;
  logic [CNT_W-1:0] period_value;
  logic [7:0]       next_hardware_limit_control;
  logic [4:0]       next_external_reset_select;
  logic             next_on_bit;
  logic [CNT_W-1:0] next_period_value;

  // Timer state.
  thl_state_e                state;
  thl_state_e                next_state;
  logic [CNT_W-1:0]          timer_count;
  logic [CNT_W-1:0]          next_timer_count;
  logic                      prev_clk;
  logic                      next_prev_clk;
  logic                      pend;
  logic                      next_pend;
  logic [ENSYNC_DEPTH-1:0]   en_pipe;
  logic [ENSYNC_DEPTH-1:0]   next_en_pipe;
  logic                      ext_prev;
  logic                      next_ext_prev;
  logic                      match;
  logic                      next_match;
  logic                      running;
  logic                      next_running;

  // Bus answer state.
  logic [DATA_W-1:0] readdata;
  logic [DATA_W-1:0] next_readdata;
  logic              waitreq;
  logic              next_waitreq;

  // Decoded control fields and helper terms.
  logic             prescaler_sync_enable;
  logic             clock_edge_select;
  logic             enable_sync_enable;
  logic [4:0]       mode_code;
  logic             edge_mode;
  logic             level_mode;
  logic             raw_tick;
  logic             instr_ok;
  logic             cnt_tick;
  logic             on_eff;
  logic             ext_raw;
  logic             ext_sync;
  logic             ext_at_reset;
  logic             ext_edge_hit;
  logic             one_shot_done;
  logic             bus_req;
  logic             wr_take;
  logic [DATA_W-1:0] rd_mux;

  // Field decode of the hardware-limit control register.
  assign prescaler_sync_enable = hardware_limit_control[PSC_SYNC_BIT];
  assign clock_edge_select     = hardware_limit_control[EDGE_SEL_BIT];
  assign enable_sync_enable    = hardware_limit_control[EN_SYNC_BIT];
  assign mode_code             = hardware_limit_control[MODE_MSB:0];

  assign edge_mode  = (mode_code == MODE_EDGE_RISE) || (mode_code == MODE_EDGE_FALL) ||
                      (mode_code == MODE_EDGE_BOTH);
  assign level_mode = (mode_code == MODE_LVL_LOW) || (mode_code == MODE_LVL_HIGH);

  // Source selection happens before synchronisation so that a code change
  // glitch is filtered the same way as a real edge on the source.
  thl_src_sel #(
    .OWN_CODE (OWN_CODE)
  ) u_src_sel (
    .code_i (external_reset_select),
    .pin_i  (timer_input_pin_select_i),
    .tmr_i  (other_timer_postscaled_out_i),
    .ccp_i  (capture_compare_out_i),
    .pwm_i  (pulse_width_out_i),
    .cmp_i  (synced_comparator_out_i),
    .zcd_i  (zero_cross_out_i),
    .lc_i   (logic_cell_out_i),
    .src_o  (ext_raw)
  );

  // Sources come from unrelated logic, so they are retimed before use.
  thl_sync2 #(
    .WIDTH (1)
  ) u_ext_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (ext_raw),
    .q_o   (ext_sync)
  );

  // Input clock edge of the chosen polarity; this is the prescaler output
  // at a ratio of one, since the prescaler itself lives elsewhere.
  assign raw_tick = clock_edge_select ? (prev_clk && !timer_input_clock_i)
                                      : (!prev_clk && timer_input_clock_i);

  // The instruction clock stops in sleep, so a retimed timer stops with it.
  assign instr_ok = instr_clk_en_i && !sleep_i;

  // Retimed ticks only step the count on an instruction clock, so a read
  // never sees the count mid-change with respect to the processor.
  assign cnt_tick = prescaler_sync_enable ? (pend && instr_ok) : raw_tick;

  // The enable either acts at once or after passing two input clock edges.
  assign on_eff = enable_sync_enable ? en_pipe[ENSYNC_DEPTH-1] : on_bit;

  // External reset level and edge terms for the special modes.
  assign ext_at_reset = (mode_code == MODE_LVL_LOW) ? !ext_sync : ext_sync;

  always_comb begin
    unique case (mode_code)
      MODE_EDGE_RISE: ext_edge_hit = ext_sync && !ext_prev;
      MODE_EDGE_FALL: ext_edge_hit = !ext_sync && ext_prev;
      default:        ext_edge_hit = ext_sync ^ ext_prev;
    endcase
  end

  // A level one-shot that reaches its period gives the enable back.
  assign one_shot_done = level_mode && (state == ST_RUN) && !ext_at_reset && cnt_tick &&
                         (timer_count == period_value);

  // Bus decode: a write with byte lane 0 enabled takes effect in the cycle its waitrequest is low.
  assign bus_req = avs_read_i || avs_write_i;
  assign wr_take = avs_write_i && !waitreq && avs_byteenable_i[0];

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_mux = '0;
    unique case (avs_address_i)
      OFS_HLC:  rd_mux[7:0] = hardware_limit_control;
      OFS_SRC:  rd_mux[SRC_SEL_MSB:0] = external_reset_select;
      OFS_CON:  rd_mux[ON_BIT] = on_bit;
      OFS_PER:  rd_mux[CNT_W-1:0] = period_value;
      OFS_CNT:  rd_mux[CNT_W-1:0] = timer_count;
      OFS_STAT: begin
        rd_mux[STAT_RUN] = running;
        rd_mux[STAT_ON]  = on_eff;
        rd_mux[STAT_EXT] = ext_sync;
      end
      default:  rd_mux = '0;
    endcase
  end

  // Register file next values; a software write of the enable wins over
  // a hardware clear landing in the same cycle.
  always_comb begin
    next_hardware_limit_control = hardware_limit_control;
    next_external_reset_select  = external_reset_select;
    next_on_bit                 = on_bit;
    next_period_value           = period_value;
    if (ce_i) begin
      if (one_shot_done) begin
        next_on_bit = 1'b0;
      end
      if (wr_take) begin
        unique case (avs_address_i)
          OFS_HLC:  next_hardware_limit_control = avs_writedata_i[7:0];
          OFS_SRC:  next_external_reset_select = avs_writedata_i[SRC_SEL_MSB:0];
          OFS_CON:  next_on_bit = avs_writedata_i[ON_BIT];
          OFS_PER:  next_period_value = avs_writedata_i[CNT_W-1:0];
          default:  next_on_bit = next_on_bit;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hardware_limit_control <= HLC_RST;
      external_reset_select  <= SRC_SEL_RST;
      on_bit                 <= 1'b0;
      period_value           <= PER_RST[CNT_W-1:0];
    end else begin
      hardware_limit_control <= next_hardware_limit_control;
      external_reset_select  <= next_external_reset_select;
      on_bit                 <= next_on_bit;
      period_value           <= next_period_value;
    end
  end

  // Timer sequencing. Disabling halts the count where it stands, except in
  // the level one-shot modes, which hold the count in reset while off.
  always_comb begin
    next_state       = state;
    next_timer_count = timer_count;
    next_prev_clk    = prev_clk;
    next_pend        = pend;
    next_en_pipe     = en_pipe;
    next_ext_prev    = ext_prev;
    next_match       = match;
    next_running     = running;
    if (ce_i) begin
      next_prev_clk = timer_input_clock_i;
      next_ext_prev = ext_sync;
      next_match    = 1'b0;
      // The enable shifts in only on input clock edges. The stages stay clear
      // while retiming is off, so turning it on never acts on a stale enable.
      if (!enable_sync_enable) begin
        next_en_pipe = '0;
      end else if (raw_tick) begin
        next_en_pipe = {en_pipe[ENSYNC_DEPTH-2:0], on_bit};
      end
      // A new edge arriving as the pending one is consumed stays pending.
      next_pend = prescaler_sync_enable && ((pend && !instr_ok) || raw_tick);
      if (!on_eff) begin
        next_state = ST_OFF;
        next_pend  = 1'b0;
        if (level_mode) begin
          next_timer_count = '0;
        end
      end else begin
        unique case (state)
          ST_OFF: begin
            next_state = edge_mode ? ST_ARM : ST_RUN;
          end
          ST_ARM: begin
            if (edge_mode && ext_edge_hit) begin
              next_state = ST_RUN;
            end
          end
          ST_RUN: begin
            if (level_mode && ext_at_reset) begin
              next_timer_count = '0;
            end else if (cnt_tick) begin
              if (timer_count == period_value) begin
                next_timer_count = '0;
                next_match       = 1'b1;
                if (edge_mode || level_mode) begin
                  next_state = ST_ARM;
                end
              end else begin
                next_timer_count = timer_count + 1'b1;
              end
            end
          end
        endcase
      end
      next_running = (next_state == ST_RUN);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= ST_OFF;
      timer_count <= CNT_RST[CNT_W-1:0];
      prev_clk    <= 1'b0;
      pend        <= 1'b0;
      en_pipe     <= '0;
      ext_prev    <= 1'b0;
      match       <= 1'b0;
      running     <= 1'b0;
    end else begin
      state       <= next_state;
      timer_count <= next_timer_count;
      prev_clk    <= next_prev_clk;
      pend        <= next_pend;
      en_pipe     <= next_en_pipe;
      ext_prev    <= next_ext_prev;
      match       <= next_match;
      running     <= next_running;
    end
  end

  // Bus answer: waitrequest idles high and drops for exactly one cycle
  // after a request is seen. This costs a cycle per access but keeps the
  // read data and waitrequest straight from flops.
  always_comb begin
    next_waitreq  = waitreq;
    next_readdata = readdata;
    if (ce_i) begin
      next_waitreq = 1'b1;
      if (bus_req && waitreq) begin
        next_waitreq  = 1'b0;
        next_readdata = avs_read_i ? rd_mux : '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waitreq  <= 1'b1;
      readdata <= '0;
    end else begin
      waitreq  <= next_waitreq;
      readdata <= next_readdata;
    end
  end

  // Outputs are taken straight from flops.
  assign avs_waitrequest_o = waitreq;
  assign avs_readdata_o    = readdata;
  assign timer_count_o     = timer_count;
  assign timer_match_o     = match;
  assign timer_running_o   = running;

endmodule

// ### inc/thl_pkg.sv
// Package for the hardware-limit timer control block.
// Assumes byte addresses on a 32-bit Avalon-MM slave and an 8-bit count.
package thl_pkg;

  // Bus geometry and register byte offsets.
  localparam int          ADDR_W   = 5;
  localparam int          DATA_W   = 32;
  localparam logic [4:0]  OFS_HLC  = 5'h00;
  localparam logic [4:0]  OFS_SRC  = 5'h04;
  localparam logic [4:0]  OFS_CON  = 5'h08;
  localparam logic [4:0]  OFS_PER  = 5'h0c;
  localparam logic [4:0]  OFS_CNT  = 5'h10;
  localparam logic [4:0]  OFS_STAT = 5'h14;

  // Field positions.
  localparam int PSC_SYNC_BIT = 7;
  localparam int EDGE_SEL_BIT = 6;
  localparam int EN_SYNC_BIT  = 5;
  localparam int MODE_MSB     = 4;
  localparam int SRC_SEL_MSB  = 4;
  localparam int ON_BIT     = 7;
  localparam int STAT_RUN   = 0;
  localparam int STAT_ON    = 1;
  localparam int STAT_EXT   = 2;

  // Reset values.
  localparam logic [7:0] HLC_RST     = 8'h00;
  localparam logic [4:0] SRC_SEL_RST = 5'h00;
  localparam logic [7:0] PER_RST     = 8'hff;
  localparam logic [7:0] CNT_RST     = 8'h00;

  // Mode codes with special start, stop and reset behaviour.
  localparam logic [4:0] MODE_EDGE_RISE = 5'h11;
  localparam logic [4:0] MODE_EDGE_FALL = 5'h12;
  localparam logic [4:0] MODE_EDGE_BOTH = 5'h13;
  localparam logic [4:0] MODE_LVL_LOW   = 5'h16;
  localparam logic [4:0] MODE_LVL_HIGH  = 5'h17;

  // Reset source codes: first code of each group.
  localparam logic [4:0] SRC_PIN    = 5'h00;
  localparam logic [4:0] SRC_TMR_LO = 5'h01;
  localparam logic [4:0] SRC_CCP_LO = 5'h05;
  localparam logic [4:0] SRC_PWM_LO = 5'h09;
  localparam logic [4:0] SRC_CMP_LO = 5'h11;
  localparam logic [4:0] SRC_ZCD    = 5'h19;
  localparam logic [4:0] SRC_LC_LO  = 5'h1a;
  localparam logic [4:0] SRC_RSV_LO = 5'h1e;

  // Depth of the enable synchroniser, in timer input clocks.
  localparam int ENSYNC_DEPTH = 2;

  // Timer sequencing states.
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ARM = 3'b010,
    ST_RUN = 3'b100
  } thl_state_e;

endpackage

// ### core/thl_sync2.sv
// Two-flop level synchroniser.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/10ps
module thl_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // The first stage feeds only the second stage.
  always_comb begin
    next_meta = ce_i ? d_i : meta;
    next_q    = ce_i ? meta : q_o;
  end

  // Both stages clear together on reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule

// ### core/thl_src_sel.sv
// Selector for the timer's external reset source.
// Assumes all source signals are plain levels from on-chip logic or a pin.
`timescale 1ns/10ps
module thl_src_sel
  import thl_pkg::*;
#(
  parameter logic [4:0] OWN_CODE = 5'h01
) (
  input  wire logic [4:0] code_i,
  input  wire logic       pin_i,
  input  wire logic [3:0] tmr_i,
  input  wire logic [3:0] ccp_i,
  input  wire logic [7:0] pwm_i,
  input  wire logic [7:0] cmp_i,
  input  wire logic       zcd_i,
  input  wire logic [3:0] lc_i,
  output logic            src_o
);

  logic [31:0] src_vec;

  // Sources packed in code order; the top two codes are reserved and read low.
  assign src_vec = {2'b00, lc_i, zcd_i, cmp_i, pwm_i, ccp_i, tmr_i, pin_i};

  // A timer never resets itself from its own output, so that code is dead.
  always_comb begin
    if (code_i == OWN_CODE || code_i >= SRC_RSV_LO) begin
      src_o = 1'b0;
    end else begin
      src_o = src_vec[code_i];
    end
  end

endmodule

// ### tb/thl_src_model.sv
// Model of the on-chip logic that feeds the timer's external reset sources.
// Assumes the bench picks one code and one level; every other source shows the opposite level.
`timescale 1ns/10ps
module thl_src_model (
  input  wire logic       clk_i,
  input  wire logic [4:0] code_i,
  input  wire logic       lvl_i,
  output logic            pin_o,
  output logic [3:0]      tmr_o,
  output logic [3:0]      ccp_o,
  output logic [7:0]      pwm_o,
  output logic [7:0]      cmp_o,
  output logic            zcd_o,
  output logic [3:0]      lc_o
);
  logic [31:0] all_q;

  // Unselected lines are driven inverted, so a wrong source mapping shows at once.
  always_ff @(posedge clk_i) begin
    all_q         <= {32{~lvl_i}};
    all_q[code_i] <= lvl_i;
  end

  // Code 0 is the pin, then timers, captures, pulse-width, comparators, zero-cross, cells.
  assign pin_o = all_q[0];
  assign tmr_o = all_q[4:1];
  assign ccp_o = all_q[8:5];
  assign pwm_o = all_q[16:9];
  assign cmp_o = all_q[24:17];
  assign zcd_o = all_q[25];
  assign lc_o  = all_q[29:26];
endmodule

// ### tb/thl_core_sva.sv
// Checker for the timer control block, bound to its top module.
// Assumes ce_i is high whenever the bus answer timing is relied on.
`timescale 1ns/10ps
module thl_core_chk #(
  parameter int CNT_W = 8
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             ce_i,
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic [31:0]      avs_readdata_o,
  input wire logic             avs_waitrequest_o,
  input wire logic [CNT_W-1:0] timer_count_o,
  input wire logic             timer_match_o,
  input wire logic             timer_running_o
);
  // All checks live in the one clock domain.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i
    |=> !avs_waitrequest_o) else $error("bus request not answered in one cycle");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=>
    timer_count_o == '0 && !timer_running_o && !timer_match_o && avs_waitrequest_o)
    else $error("reset does not clear timer state");
  a_count_step: assert property (timer_count_o != $past(timer_count_o) |->
    timer_count_o == '0 || timer_count_o == $past(timer_count_o) + 1'b1)
    else $error("count moved other than by one or to zero");
  a_match_zero: assert property (timer_match_o |-> timer_count_o == '0)
    else $error("match pulse without cleared count");
  a_match_pulse: assert property (timer_match_o |=> !timer_match_o)
    else $error("match pulse longer than one cycle");
  a_run_gate: assert property (timer_count_o != $past(timer_count_o) && timer_count_o != '0
    |-> $past(timer_running_o) || timer_running_o) else $error("count advanced while stopped");

  // Main scenarios reached.
  c_match: cover property (timer_match_o);
  c_start: cover property ($rose(timer_running_o));
  c_read:  cover property (avs_read_i && !avs_waitrequest_o);
endmodule

bind thl_core thl_core_chk #(.CNT_W(CNT_W)) i_thl_core_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .timer_count_o(timer_count_o),
  .timer_match_o(timer_match_o), .timer_running_o(timer_running_o));

// ### tb/test_thl_core.sv
// Self-checking bench for the timer control block and its reset source selector.
// Assumes the bus answers after waitrequest falls and the input clock is a level on clk_i.
`timescale 1ns/10ps
module test_thl_core;
  import thl_pkg::*;
  logic clk_i = 0, rst_i = 1, rd = 0, wr = 0, tic = 0, ien = 0, slp = 0, lvl = 0;
  logic [4:0] adr = '0, code = '0;
  logic [31:0] wdat = '0, rdat;
  logic [3:0] be = 4'hf, tmr, ccp, lc;
  logic [7:0] pwm, cmp, cnt;
  logic pin, zcd, wrq, mat, run;
  int num_errors = 0, cmp_count = 0, mat_n = 0;

  always #2 clk_i = ~clk_i;
  // Instruction clock tick every fourth cycle.
  always @(posedge clk_i) ien <= ($time % 16) < 4;
  // Match pulses stand one cycle, so each edge that sees one high is one match.
  always @(posedge clk_i)
    if (mat === 1'b1) mat_n <= mat_n + 1;

  thl_core i_thl_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .timer_input_clock_i(tic),
    .instr_clk_en_i(ien), .sleep_i(slp), .timer_input_pin_select_i(pin),
    .other_timer_postscaled_out_i(tmr), .capture_compare_out_i(ccp),
    .pulse_width_out_i(pwm), .synced_comparator_out_i(cmp), .zero_cross_out_i(zcd),
    .logic_cell_out_i(lc), .timer_count_o(cnt), .timer_match_o(mat), .timer_running_o(run));
  thl_src_model i_thl_src_model (.clk_i(clk_i), .code_i(code), .lvl_i(lvl), .pin_o(pin),
    .tmr_o(tmr), .ccp_o(ccp), .pwm_o(pwm), .cmp_o(cmp), .zcd_o(zcd), .lc_o(lc));

  // One bus cycle; the request is held until waitrequest is seen low.
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a; wdat <= d; wr <= w; rd <= ~w;
    @(posedge clk_i);
    while (wrq !== 1'b0) @(posedge clk_i);
    wr <= 0; rd <= 0;
  endtask
  task automatic wrr(input logic [4:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    bus(a, 1'b0, '0);
    chk(rdat, exp);
  endtask
  // Input clock half step and whole pulses; slow enough for the instruction tick.
  task automatic half(input logic v);
    @(posedge clk_i) tic <= v;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin half(1); half(0); end
  endtask
  // Change the selected source level and let it cross the synchroniser.
  task automatic src(input logic v);
    @(posedge clk_i) lvl <= v;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic test_done;
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    test_done;
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    // Reset values, field widths, read-only and unmapped places.
    rdc(OFS_HLC, 32'h00);
    rdc(OFS_SRC, 32'h00);
    rdc(OFS_PER, 32'hff);
    rdc(5'h18, 32'h00);
    wrr(OFS_SRC, 32'hff);
    rdc(OFS_SRC, 32'h1f);
    be <= 4'h0;
    wrr(OFS_SRC, 32'h00);
    be <= 4'hf;
    rdc(OFS_SRC, 32'h1f);
    wrr(OFS_HLC, 32'hff);
    rdc(OFS_HLC, 32'hff);
    wrr(OFS_HLC, 32'h00);
    wrr(OFS_CNT, 32'h55);
    rdc(OFS_CNT, 32'h00);
    // Every source code at both levels; own and reserved codes stay inactive.
    for (int v = 0; v < 2; v++) begin
      for (int c = 0; c < 32; c++) begin
        code <= c[4:0];
        lvl <= v[0];
        wrr(OFS_SRC, c);
        repeat (4) @(posedge clk_i);
        rdc(OFS_STAT, {29'h0, (c != 1 && c < 30) ? v[0] : 1'b0, 2'b00});
      end
    end
    code <= 5'h00;
    wrr(OFS_SRC, 32'h00);
    src(0);
    // Free run with wrap at the period, then a halt that keeps the count.
    wrr(OFS_PER, 32'h03);
    wrr(OFS_CON, 32'h80);
    pulse(6);
    rdc(OFS_CNT, 32'h02);
    chk({24'h0, cnt}, 32'h02);
    chk({31'h0, run}, 32'h1);
    chk(mat_n, 32'h1);
    wrr(OFS_CON, 32'h00);
    pulse(2);
    rdc(OFS_CNT, 32'h02);
    chk({31'h0, run}, 32'h0);
    // Falling edge polarity, changed only while off.
    wrr(OFS_HLC, 32'h40);
    wrr(OFS_CON, 32'h80);
    half(1);
    rdc(OFS_CNT, 32'h02);
    half(0);
    rdc(OFS_CNT, 32'h03);
    // Prescaler retimed to the instruction clock; frozen while asleep.
    wrr(OFS_CON, 32'h00);
    wrr(OFS_HLC, 32'h80);
    wrr(OFS_CON, 32'h80);
    pulse(1);
    rdc(OFS_CNT, 32'h00);
    slp <= 1;
    pulse(2);
    rdc(OFS_CNT, 32'h00);
    // Switch off before waking, so an edge held over from sleep is dropped.
    wrr(OFS_CON, 32'h00);
    slp <= 0;
    // Enable retimed to the input clock: two input clocks pass uncounted.
    wrr(OFS_HLC, 32'h20);
    wrr(OFS_CON, 32'h80);
    pulse(2);
    rdc(OFS_CNT, 32'h00);
    pulse(1);
    rdc(OFS_CNT, 32'h01);
    // Level one-shot, high reset level: match clears count and the on bit.
    wrr(OFS_CON, 32'h00);
    wrr(OFS_HLC, 32'h17);
    wrr(OFS_PER, 32'h02);
    wrr(OFS_CON, 32'h80);
    pulse(3);
    rdc(OFS_CNT, 32'h00);
    rdc(OFS_CON, 32'h00);
    wrr(OFS_CON, 32'h80);
    src(1);
    pulse(2);
    rdc(OFS_CNT, 32'h00);
    src(0);
    pulse(1);
    rdc(OFS_CNT, 32'h01);
    // Level one-shot, low reset level: a low source holds the count at zero.
    wrr(OFS_CON, 32'h00);
    wrr(OFS_HLC, 32'h16);
    wrr(OFS_CON, 32'h80);
    pulse(1);
    rdc(OFS_CNT, 32'h00);
    src(1);
    pulse(1);
    rdc(OFS_CNT, 32'h01);
    // Edge monostable modes: rising, falling, either edge.
    for (int m = 0; m < 3; m++) begin
      wrr(OFS_CON, 32'h00);
      wrr(OFS_HLC, 32'h17);
      wrr(OFS_HLC, 32'h11 + m);
      src(m == 1);
      wrr(OFS_CON, 32'h80);
      pulse(1);
      rdc(OFS_CNT, 32'h00);
      chk({31'h0, run}, 32'h0);
      src(m != 1);
      pulse(2);
      rdc(OFS_CNT, 32'h02);
      pulse(2);
      rdc(OFS_CNT, 32'h00);
    end
    chk(mat_n, 32'h6);
    test_done;
  end
endmodule
